// ---- rtl/rtoi_consts.vh ----
// register indices, field positions, reset values and frame counts
`ifndef RTOI_CONSTS_VH
`define RTOI_CONSTS_VH
// register indices; byte address is four times the index
`define RTOI_IDX_STATE 10'h207
`define RTOI_IDX_FSTAT 10'h20B
`define RTOI_IDX_LEN 10'h20D
`define RTOI_IDX_OEN 10'h20E
`define RTOI_IDX_FEN 10'h20F
`define RTOI_IDX_OSTAT 10'h210
`define RTOI_IDX_LSTAT 10'h211
`define RTOI_IDX_CTRL 10'h212
`define RTOI_IDX_S1 10'h213
// select codes out of the address decoder
`define RTOI_SEL_NONE 4'h0
`define RTOI_SEL_STATE 4'h1
`define RTOI_SEL_FSTAT 4'h2
`define RTOI_SEL_LEN 4'h3
`define RTOI_SEL_OEN 4'h4
`define RTOI_SEL_FEN 4'h5
`define RTOI_SEL_OSTAT 4'h6
`define RTOI_SEL_LSTAT 4'h7
`define RTOI_SEL_CTRL 4'h8
`define RTOI_SEL_S1 4'h9
// field positions
`define RTOI_B_LOS 0
`define RTOI_B_SEF 1
`define RTOI_B_LOF 2
`define RTOI_B_RDI 0
`define RTOI_B_AIS 1
`define RTOI_B_NEWK 0
`define RTOI_B_KUNS 1
`define RTOI_B_TMIS 3
`define RTOI_B_NEWT 4
`define RTOI_B_TUNS 5
`define RTOI_B_S1UNS 6
`define RTOI_B_NEWS1 7
// writable masks and reset values
`define RTOI_LEN_MASK 8'h03
`define RTOI_OEN_MASK 8'hFB
`define RTOI_FEN_MASK 8'h07
`define RTOI_CTRL_MASK 8'h01
`define RTOI_RST_BYTE 8'h00
// frames of repetition, counted from zero
`define RTOI_S1_LAST 3'h7
`define RTOI_K_LAST3 3'h2
`define RTOI_K_LAST5 3'h4
`endif

// ---- rtl/rtoi_core.v ----
// receive transport overhead interrupt status and enable block
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// How it works
// - flag set on every LOF change
// - flag set on every SEF change
// - flag set on every LOS change
// - change flags clear when host reads them
// - live LOF state readable in state byte
// - live SEF state readable in state byte
// - live LOS state readable in state byte
// - enable bit gates AIS-L change interrupt
// - enable bit gates RDI-L change interrupt
// - line enable register: bits 1:0 writable
// - new S1 value raises interrupt when enabled
// - S1 accepted after 8 identical frames
// - overhead enable register, bit 2 read-only
// - defect change interrupts only while enabled
// - LOS, SEF, LOF change flags in bits 0-2
// - K1/K2 accepted after 3 or 5 frames
// ****************************************************************
`include "rtoi_consts.vh"

module rtoi_core (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire los_state,
  input wire sef_state,
  input wire lof_state,
  input wire ais_l_state,
  input wire rdi_l_state,
  input wire frame_tick,
  input wire [7:0] s1_rx_byte,
  input wire [7:0] k1_rx_byte,
  input wire [7:0] k2_rx_byte,
  input wire s1_unstable_chg,
  input wire trace_unstable_chg,
  input wire trace_new,
  input wire trace_mismatch_chg,
  input wire k_unstable_chg,
  output reg [7:0] s1_accepted_r,
  output reg [15:0] k_accepted_r,
  output wire irq,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function [3:0] rtoi_sel;
    input [11:0] addr;
    begin
      case (addr[11:2])
        `RTOI_IDX_STATE: rtoi_sel = `RTOI_SEL_STATE;
        `RTOI_IDX_FSTAT: rtoi_sel = `RTOI_SEL_FSTAT;
        `RTOI_IDX_LEN: rtoi_sel = `RTOI_SEL_LEN;
        `RTOI_IDX_OEN: rtoi_sel = `RTOI_SEL_OEN;
        `RTOI_IDX_FEN: rtoi_sel = `RTOI_SEL_FEN;
        `RTOI_IDX_OSTAT: rtoi_sel = `RTOI_SEL_OSTAT;
        `RTOI_IDX_LSTAT: rtoi_sel = `RTOI_SEL_LSTAT;
        `RTOI_IDX_CTRL: rtoi_sel = `RTOI_SEL_CTRL;
        `RTOI_IDX_S1: rtoi_sel = `RTOI_SEL_S1;
        default: rtoi_sel = `RTOI_SEL_NONE;
      endcase
    end
  endfunction

  reg [7:0] fstat_r;
  reg [7:0] fstat_nxt;
  reg [7:0] ostat_r;
  reg [7:0] ostat_nxt;
  reg [7:0] lstat_r;
  reg [7:0] lstat_nxt;
  reg [7:0] len_r;
  reg [7:0] oen_r;
  reg [7:0] fen_r;
  reg [7:0] ctrl_r;
  reg [4:0] prev_r;
  reg [7:0] s1_cand_r;
  reg [2:0] s1_cnt_r;
  reg [15:0] k_cand_r;
  reg [2:0] k_cnt_r;
  reg s1_new;
  reg k_new;
  reg aw_held_r;
  reg w_held_r;
  reg [11:0] aw_addr_r;
  reg [7:0] w_byte_r;
  reg w_lane_r;
  wire [4:0] live;
  wire [4:0] chg;
  wire [15:0] k_rx;
  wire [2:0] k_last;
  wire wr_go;
  wire rd_go;
  wire [3:0] wr_sel;
  wire [3:0] rd_sel;
  wire [7:0] state_byte;

  assign live = {rdi_l_state, ais_l_state, lof_state, sef_state, los_state};
  assign k_rx = {k1_rx_byte, k2_rx_byte};

  // ****************************************************************
  // change detection
  // ****************************************************************
  // one edge detector per watched defect level
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_chg
      assign chg[gi] = live[gi] ^ prev_r[gi];
    end
  endgenerate

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_r <= 5'h00;
    end else if (ce) begin
      prev_r <= live;
    end
  end

  // ****************************************************************
  // overhead byte acceptance filters
  // ****************************************************************
  // eight equal S1 frames
  always @* begin
    s1_new = frame_tick && (s1_rx_byte == s1_cand_r) &&
             (s1_cnt_r == `RTOI_S1_LAST - 3'h1) && (s1_rx_byte != s1_accepted_r);
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_cand_r <= 8'h00;
      s1_cnt_r <= 3'h0;
      s1_accepted_r <= 8'h00;
    end else if (ce && frame_tick) begin
      if (s1_rx_byte != s1_cand_r) begin
        s1_cand_r <= s1_rx_byte;
        s1_cnt_r <= 3'h0;
      end else if (s1_cnt_r != `RTOI_S1_LAST) begin
        s1_cnt_r <= s1_cnt_r + 3'h1;
      end
      if (s1_new) begin
        s1_accepted_r <= s1_rx_byte;
      end
    end
  end

  // three or five equal K1/K2 frames
  assign k_last = ctrl_r[0] ? `RTOI_K_LAST5 : `RTOI_K_LAST3;

  always @* begin
    k_new = frame_tick && (k_rx == k_cand_r) &&
            (k_cnt_r == k_last - 3'h1) && (k_rx != k_accepted_r);
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      k_cand_r <= 16'h0000;
      k_cnt_r <= 3'h0;
      k_accepted_r <= 16'h0000;
    end else if (ce && frame_tick) begin
      if (k_rx != k_cand_r) begin
        k_cand_r <= k_rx;
        k_cnt_r <= 3'h0;
      end else if (k_cnt_r < k_last) begin
        k_cnt_r <= k_cnt_r + 3'h1;
      end
      if (k_new) begin
        k_accepted_r <= k_rx;
      end
    end
  end

  // ****************************************************************
  // register bus handshakes
  // ****************************************************************
  // address and data may land in either order; one write at a time
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_sel = rtoi_sel(aw_addr_r);
  assign rd_sel = rtoi_sel(s_axi_araddr);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == `RTOI_SEL_NONE) ? 2'h3 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // enable and control registers
  // ****************************************************************
  // writes without byte lane 0 change nothing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      len_r <= `RTOI_RST_BYTE;
      oen_r <= `RTOI_RST_BYTE;
      fen_r <= `RTOI_RST_BYTE;
      ctrl_r <= `RTOI_RST_BYTE;
    end else if (ce && wr_go && w_lane_r) begin
      case (wr_sel)
        `RTOI_SEL_LEN: len_r <= w_byte_r & `RTOI_LEN_MASK;
        `RTOI_SEL_OEN: oen_r <= w_byte_r & `RTOI_OEN_MASK;
        `RTOI_SEL_FEN: fen_r <= w_byte_r & `RTOI_FEN_MASK;
        `RTOI_SEL_CTRL: ctrl_r <= w_byte_r & `RTOI_CTRL_MASK;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // ****************************************************************
  // sticky change flags
  // ****************************************************************
  // a new event in the read cycle survives the clear
  always @* begin
    fstat_nxt = fstat_r;
    ostat_nxt = ostat_r;
    lstat_nxt = lstat_r;
    if (rd_go && rd_sel == `RTOI_SEL_FSTAT) begin
      fstat_nxt = 8'h00;
    end
    if (rd_go && rd_sel == `RTOI_SEL_OSTAT) begin
      ostat_nxt = 8'h00;
    end
    if (rd_go && rd_sel == `RTOI_SEL_LSTAT) begin
      lstat_nxt = 8'h00;
    end
    fstat_nxt[`RTOI_B_LOS] = fstat_nxt[`RTOI_B_LOS] | chg[0];
    fstat_nxt[`RTOI_B_SEF] = fstat_nxt[`RTOI_B_SEF] | chg[1];
    fstat_nxt[`RTOI_B_LOF] = fstat_nxt[`RTOI_B_LOF] | chg[2];
    lstat_nxt[`RTOI_B_AIS] = lstat_nxt[`RTOI_B_AIS] | chg[3];
    lstat_nxt[`RTOI_B_RDI] = lstat_nxt[`RTOI_B_RDI] | chg[4];
    // accepted S1 value is an event
    ostat_nxt[`RTOI_B_NEWS1] = ostat_nxt[`RTOI_B_NEWS1] | s1_new;
    ostat_nxt[`RTOI_B_S1UNS] = ostat_nxt[`RTOI_B_S1UNS] | s1_unstable_chg;
    ostat_nxt[`RTOI_B_TUNS] = ostat_nxt[`RTOI_B_TUNS] | trace_unstable_chg;
    ostat_nxt[`RTOI_B_NEWT] = ostat_nxt[`RTOI_B_NEWT] | trace_new;
    ostat_nxt[`RTOI_B_TMIS] = ostat_nxt[`RTOI_B_TMIS] | trace_mismatch_chg;
    ostat_nxt[`RTOI_B_KUNS] = ostat_nxt[`RTOI_B_KUNS] | k_unstable_chg;
    ostat_nxt[`RTOI_B_NEWK] = ostat_nxt[`RTOI_B_NEWK] | k_new;
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fstat_r <= `RTOI_RST_BYTE;
      ostat_r <= `RTOI_RST_BYTE;
      lstat_r <= `RTOI_RST_BYTE;
    end else if (ce) begin
      fstat_r <= fstat_nxt;
      ostat_r <= ostat_nxt;
      lstat_r <= lstat_nxt;
    end
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  // OR of enabled sticky flags
  assign irq = |(fstat_r & fen_r) | |(lstat_r & len_r) | |(ostat_r & oen_r);

  // ****************************************************************
  // read path
  // ****************************************************************
  // live LOF in bit 2
  assign state_byte = {5'h00, lof_state, sef_state, los_state};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (rd_sel)
          `RTOI_SEL_STATE: s_axi_rdata <= {24'h000000, state_byte};
          `RTOI_SEL_FSTAT: s_axi_rdata <= {24'h000000, fstat_r};
          `RTOI_SEL_LEN: s_axi_rdata <= {24'h000000, len_r};
          `RTOI_SEL_OEN: s_axi_rdata <= {24'h000000, oen_r};
          `RTOI_SEL_FEN: s_axi_rdata <= {24'h000000, fen_r};
          `RTOI_SEL_OSTAT: s_axi_rdata <= {24'h000000, ostat_r};
          `RTOI_SEL_LSTAT: s_axi_rdata <= {24'h000000, lstat_r};
          `RTOI_SEL_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
          `RTOI_SEL_S1: s_axi_rdata <= {24'h000000, s1_accepted_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rtoi_core
`default_nettype wire

// ---- tb/rtoi_assertions.sv ----
// checker for the transport overhead interrupt block
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module rtoi_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic frame_tick,
  input wire logic [7:0] s1_rx_byte,
  input wire logic [7:0] k1_rx_byte,
  input wire logic [7:0] k2_rx_byte,
  input wire logic [7:0] s1_accepted_r,
  input wire logic [15:0] k_accepted_r,
  input wire logic irq,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_s1_accept: assert property ($changed(s1_accepted_r) |-> $past(frame_tick) && s1_accepted_r == $past(s1_rx_byte))
    else $error("s1 accepted without frame");
  a_k_accept: assert property (
    $changed(k_accepted_r) |-> $past(frame_tick) && k_accepted_r == {$past(k1_rx_byte), $past(k2_rx_byte)})
    else $error("k pair accepted without frame");
  // irq only drops after a clearing read or an enable write
  a_irq_fall: assert property ($fell(irq) |-> $rose(s_axi_bvalid) || $past(s_axi_arvalid && s_axi_arready))
    else $error("irq dropped without cause");
endmodule // rtoi_assertions
bind rtoi_core rtoi_assertions u_chk (.mclk, .rst, .frame_tick, .s1_rx_byte, .k1_rx_byte, .k2_rx_byte,
  .s1_accepted_r, .k_accepted_r, .irq, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ---- tb/rtoi_host.sv ----
// host bus master model
`timescale 1ns/1ps
`default_nettype none
// ****************
// host model
// ****************
module rtoi_host (
  input wire logic mclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
    s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  // handshakes judged on settled values before each rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    // idle edge so a following call never re-raises ready in this step
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
endmodule // rtoi_host
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the transport overhead interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "rtoi_consts.vh"
module tb_top;
  logic mclk, rst, ce, frame_tick, irq;
  logic [4:0] dfx, ev;
  logic [7:0] s1_rx_byte, s1_accepted_r;
  logic [15:0] kb, k_accepted_r;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  rtoi_core dut (.mclk, .rst, .ce, .los_state(dfx[0]), .sef_state(dfx[1]), .lof_state(dfx[2]),
    .ais_l_state(dfx[3]), .rdi_l_state(dfx[4]), .frame_tick, .s1_rx_byte, .k1_rx_byte(kb[15:8]),
    .k2_rx_byte(kb[7:0]), .s1_unstable_chg(ev[4]), .trace_unstable_chg(ev[3]), .trace_new(ev[2]),
    .trace_mismatch_chg(ev[1]), .k_unstable_chg(ev[0]), .s1_accepted_r, .k_accepted_r, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rtoi_host host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ****************
  // helpers
  // ****************
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic irq_is(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [9:0] i, input logic [31:0] e);
    host.rd({i, 2'b00}, rv, rr);
    chk(rv, e);
  endtask
  task automatic wri(input logic [9:0] i, input logic [7:0] d);
    host.wr({i, 2'b00}, d, rr);
  endtask
  task automatic fr(input logic [7:0] s, input logic [15:0] k, input int n);
    repeat (n) begin
      s1_rx_byte <= s;
      kb <= k;
      frame_tick <= 1'b1;
      @(posedge mclk);
      frame_tick <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    rdc(`RTOI_IDX_LEN, 32'h0);
    rdc(`RTOI_IDX_OEN, 32'h0);
    wri(`RTOI_IDX_LEN, 8'hFF);
    chk({30'h0, rr}, 32'h0);
    rdc(`RTOI_IDX_LEN, 32'h3);
    wri(`RTOI_IDX_OEN, 8'hFF);
    rdc(`RTOI_IDX_OEN, 32'hFB);
    host.rd(12'hFFC, rv, rr);
    chk({30'h0, rr}, 32'h3);
    chk(rv, 32'h0);
    host.wr(12'hFFC, 8'h55, rr);
    chk({30'h0, rr}, 32'h3);
  endtask
  task automatic t_defect;
    wri(`RTOI_IDX_FEN, 8'h07);
    for (int i = 0; i < 3; i++) begin
      dfx[i] <= 1'b1;
      @(posedge mclk);
      irq_is(1'b1);
      rdc(`RTOI_IDX_STATE, 32'h1 << i);
      rdc(`RTOI_IDX_FSTAT, 32'h1 << i);
      irq_is(1'b0);
      rdc(`RTOI_IDX_FSTAT, 32'h0);
      dfx[i] <= 1'b0;
      @(posedge mclk);
      rdc(`RTOI_IDX_FSTAT, 32'h1 << i);
    end
  endtask
  task automatic t_line;
    wri(`RTOI_IDX_LEN, 8'h00);
    dfx[3] <= 1'b1;
    @(posedge mclk);
    irq_is(1'b0);
    wri(`RTOI_IDX_LEN, 8'h02);
    irq_is(1'b1);
    rdc(`RTOI_IDX_LSTAT, 32'h2);
    dfx[4] <= 1'b1;
    @(posedge mclk);
    irq_is(1'b0);
    wri(`RTOI_IDX_LEN, 8'h01);
    irq_is(1'b1);
    rdc(`RTOI_IDX_LSTAT, 32'h1);
  endtask
  // a broken run of equal bytes must restart the count
  task automatic t_s1;
    wri(`RTOI_IDX_OEN, 8'h80);
    fr(8'h3C, 16'h0, 7);
    fr(8'h11, 16'h0, 1);
    fr(8'h3C, 16'h0, 7);
    chk({24'h0, s1_accepted_r}, 32'h0);
    irq_is(1'b0);
    fr(8'h3C, 16'h0, 1);
    chk({24'h0, s1_accepted_r}, 32'h3C);
    irq_is(1'b1);
    rdc(`RTOI_IDX_S1, 32'h3C);
    rdc(`RTOI_IDX_OSTAT, 32'h80);
    irq_is(1'b0);
  endtask
  task automatic t_k;
    for (int m = 0; m < 2; m++) begin
      wri(`RTOI_IDX_CTRL, {7'h0, m[0]});
      fr(8'h3C, {15'h52E0, m[0]}, 2 + 2 * m);
      chk({16'h0, k_accepted_r}, (m == 1) ? 32'hA5C0 : 32'h0);
      fr(8'h3C, {15'h52E0, m[0]}, 1);
      chk({16'h0, k_accepted_r}, {16'h0, 15'h52E0, m[0]});
    end
  endtask
  task automatic t_ev;
    ev <= 5'h1F;
    @(posedge mclk);
    ev <= 5'h00;
    @(posedge mclk);
    rdc(`RTOI_IDX_OSTAT, 32'h7B);
  endtask
  // frozen while enable is low, change caught once it returns
  task automatic t_ce;
    ce <= 1'b0;
    dfx[0] <= 1'b1;
    repeat (3) @(posedge mclk);
    irq_is(1'b0);
    ce <= 1'b1;
    @(posedge mclk);
    irq_is(1'b1);
    rdc(`RTOI_IDX_FSTAT, 32'h1);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    dfx = 5'h00;
    ev = 5'h00;
    frame_tick = 1'b0;
    s1_rx_byte = 8'h00;
    kb = 16'h0000;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs;
    t_defect;
    t_line;
    t_s1;
    t_k;
    t_ev;
    t_ce;
    results;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results;
    end
  end
endmodule // tb_top
`default_nettype wire
